// file: gauge_pkg.sv
// Shared constants and types for the gauge power mode and alert controller
package gauge_pkg;
    localparam int          CLK_HZ             = 20_000_000;
    localparam int          POR_SETTLE_MS      = 250;
    localparam int          ACTIVE_PERIOD_MS   = 1000;
    localparam int          POR_SETTLE_CYC     = CLK_HZ / 1000 * POR_SETTLE_MS;
    localparam int          ACTIVE_PERIOD_CYC  = CLK_HZ / 1000 * ACTIVE_PERIOD_MS;
    localparam int          CNT_W              = 26;
    localparam logic [15:0] DESIGN_CAP_RESET   = 16'h07d0;
    localparam logic [15:0] CMD_QUICK_SENSE    = 16'h4000;
    localparam logic [15:0] CMD_SLEEP_ENTER    = 16'h0001;
    localparam logic [15:0] CMD_SLEEP_EXIT     = 16'h0002;
    localparam logic [15:0] CMD_SHDN_ENTER     = 16'h0003;
    localparam logic [15:0] CMD_SHDN_EXIT      = 16'h0004;
    localparam logic [3:0]  SLEEP_MULT_MIN     = 4'h2;
    localparam logic [3:0]  SLEEP_MULT_RESET   = 4'h4;
    localparam logic [7:0]  CHARGE_LEVEL_RESET = 8'h32;
    localparam logic [6:0]  I2C_SLAVE_ADDR     = 7'b1010101;
    localparam int          NUM_ALERTS         = 6;
    localparam int          SC_ALERT_IDX       = 5;

    typedef enum logic [2:0] {
        MODE_ACTIVE   = 3'b001,
        MODE_SLEEP    = 3'b010,
        MODE_SHUTDOWN = 3'b100
    } power_mode_t;
endpackage : gauge_pkg

// file: alert_unit.sv
// Alert flags, interrupt status and open-drain alert pin
`timescale 1ns/1ps
`default_nettype none
module alert_unit (
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire logic [gauge_pkg::NUM_ALERTS-1:0]  alert_cond,
    input  wire logic [gauge_pkg::NUM_ALERTS-1:0]  alert_en,
    input  wire logic                              irq_en,
    input  wire logic                              sc_flag_clear,
    input  wire logic                              irq_read,
    output logic      [gauge_pkg::NUM_ALERTS-1:0]  alert_flag,
    output logic                                   irq_status,
    output logic                                   alert_n_oe
);
    import gauge_pkg::*;

    logic [NUM_ALERTS-1:0] flag_reg;
    logic [NUM_ALERTS-1:0] flag_next;
    logic                  irq_reg;
    logic                  irq_next;
    logic                  rise;

    always_comb begin
        for (int i = 0; i < NUM_ALERTS; i++) begin
            if (!alert_en[i]) begin
                flag_next[i] = 1'b0;
            end else if (alert_cond[i]) begin
                flag_next[i] = 1'b1;
            end else if (i == SC_ALERT_IDX) begin
                flag_next[i] = flag_reg[i] & ~sc_flag_clear;
            end else begin
                flag_next[i] = 1'b0;
            end
        end
        // Only a newly set flag interrupts; a flag already set stays quiet
        rise     = irq_en && ((flag_next & ~flag_reg) != '0);
        // New event wins over the clearing read so nothing is lost
        irq_next = rise ? 1'b1 : (irq_read ? 1'b0 : irq_reg);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag_reg <= '0;
            irq_reg  <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            irq_reg  <= irq_next;
        end
    end

    assign alert_flag = flag_reg;
    assign irq_status = irq_reg;
    assign alert_n_oe = irq_reg;

    property p_flag_needs_en_0;
        @(posedge sys_clk) disable iff (rst)
        !alert_en[0] |=> !flag_reg[0];
    endproperty
    a_flag_needs_en_0: assert property (p_flag_needs_en_0)
        else $error("flag set while its enable was low");

    property p_flag_needs_en_1;
        @(posedge sys_clk) disable iff (rst)
        !alert_en[1] |=> !flag_reg[1];
    endproperty
    a_flag_needs_en_1: assert property (p_flag_needs_en_1)
        else $error("flag set while its enable was low");

    property p_auto_clear_ov;
        @(posedge sys_clk) disable iff (rst)
        (alert_en[2] && !alert_cond[2]) |=> !flag_reg[2];
    endproperty
    a_auto_clear_ov: assert property (p_auto_clear_ov)
        else $error("flag held after condition cleared");

    property p_auto_clear_uv;
        @(posedge sys_clk) disable iff (rst)
        (alert_en[3] && $fell(alert_cond[3])) |=> !flag_reg[3];
    endproperty
    a_auto_clear_uv: assert property (p_auto_clear_uv)
        else $error("flag held after condition cleared");

    property p_set_on_cond;
        @(posedge sys_clk) disable iff (rst)
        (alert_en[0] && alert_cond[0]) |=> flag_reg[0];
    endproperty
    a_set_on_cond: assert property (p_set_on_cond)
        else $error("enabled condition did not set flag");

    property p_sc_sticky;
        @(posedge sys_clk) disable iff (rst)
        (flag_reg[SC_ALERT_IDX] && alert_en[SC_ALERT_IDX] && !sc_flag_clear)
            |=> flag_reg[SC_ALERT_IDX];
    endproperty
    a_sc_sticky: assert property (p_sc_sticky)
        else $error("charge change flag cleared without host write");

    property p_irq_on_new_flag;
        @(posedge sys_clk) disable iff (rst)
        (irq_en && !flag_reg[4] && alert_en[4] && alert_cond[4]) |=> irq_reg;
    endproperty
    a_irq_on_new_flag: assert property (p_irq_on_new_flag)
        else $error("no interrupt after new flag");

    property p_irq_needs_en;
        @(posedge sys_clk) disable iff (rst)
        $rose(irq_reg) |-> $past(irq_en);
    endproperty
    a_irq_needs_en: assert property (p_irq_needs_en)
        else $error("interrupt rose while interrupt enable low");

    property p_irq_hold;
        @(posedge sys_clk) disable iff (rst)
        (irq_reg && !irq_read) |=> irq_reg;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("pending interrupt lost without read");

    property p_pin_follows;
        @(posedge sys_clk) disable iff (rst)
        (irq_reg && irq_read && !rise) |=> (!irq_reg && !alert_n_oe);
    endproperty
    a_pin_follows: assert property (p_pin_follows)
        else $error("read did not clear interrupt and pin");
endmodule : alert_unit
`default_nettype wire

// file: gauge_power_mode_alert_ctrl.sv
// Power mode sequencer, charge level report and alert wrapper of the gauge
`timescale 1ns/1ps
`default_nettype none
module gauge_power_mode_alert_ctrl (
    input  wire logic                             sys_clk,
    input  wire logic                             rst,
    input  wire logic                             ctrl_wr,
    input  wire logic [15:0]                      ctrl_wdata,
    input  wire logic                             design_cap_wr,
    input  wire logic [15:0]                      design_cap_wdata,
    input  wire logic [3:0]                       sleep_mult,
    input  wire logic                             shutdown_en,
    input  wire logic                             auto_sleep_req,
    input  wire logic                             scl_in,
    input  wire logic                             sda_in,
    input  wire logic [7:0]                       soc_calc,
    input  wire logic [gauge_pkg::NUM_ALERTS-1:0] alert_cond,
    input  wire logic [gauge_pkg::NUM_ALERTS-1:0] alert_en,
    input  wire logic [gauge_pkg::NUM_ALERTS-1:0] alert_thr_set,
    input  wire logic                             irq_en,
    input  wire logic                             sc_flag_clear,
    input  wire logic                             irq_read,
    output logic      [15:0]                      design_capacity_a,
    output logic      [7:0]                       charge_level_value,
    output logic                                  meas_update,
    output logic                                  soc_restart,
    output gauge_pkg::power_mode_t                power_mode,
    output logic      [gauge_pkg::NUM_ALERTS-1:0] alert_flag,
    output logic                                  irq_status,
    output logic                                  alert_n_o,
    output logic                                  alert_n_oe
);
    import gauge_pkg::*;

    // Bus-line inputs come from the pins: two stages before use
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       bus_low;

    power_mode_t mode_reg;
    power_mode_t mode_next;
    logic        by_bus_reg;
    logic        by_bus_next;
    logic [15:0] dcap_reg;
    logic [15:0] dcap_next;
    logic [7:0]  level_reg;
    logic [7:0]  level_next;
    logic        first_done_reg;
    logic        first_done_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [3:0]  tick_cnt_reg;
    logic [3:0]  tick_cnt_next;
    logic        upd_reg;
    logic        upd_next;
    logic        restart_reg;
    logic        restart_next;
    logic [3:0]  mult_eff;
    logic        quick_sense;
    logic        sec_tick;
    logic        cmd_is_sleep_in;
    logic        cmd_is_sleep_out;
    logic        cmd_is_shdn_in;
    logic        cmd_is_shdn_out;
    logic [NUM_ALERTS-1:0] armed;

    function automatic logic cmd_hit(input logic [15:0] code);
        return ctrl_wr && (ctrl_wdata == code);
    endfunction : cmd_hit

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
        end
    end

    // The device address is fixed; framing lives in the bus slave outside
    localparam logic [6:0] SLAVE_ADDR = I2C_SLAVE_ADDR;

    always_comb begin
        bus_low          = !scl_sync_reg[1] && !sda_sync_reg[1];
        quick_sense      = cmd_hit(CMD_QUICK_SENSE);
        cmd_is_sleep_in  = cmd_hit(CMD_SLEEP_ENTER);
        cmd_is_sleep_out = cmd_hit(CMD_SLEEP_EXIT);
        cmd_is_shdn_in   = cmd_hit(CMD_SHDN_ENTER);
        cmd_is_shdn_out  = cmd_hit(CMD_SHDN_EXIT);
        // Out-of-range settings fall back to the nearest legal multiple
        mult_eff = (sleep_mult < SLEEP_MULT_MIN) ? SLEEP_MULT_MIN : sleep_mult;
        armed    = alert_en | alert_thr_set;
    end

    // Power mode sequencing
    always_comb begin
        mode_next   = mode_reg;
        by_bus_next = by_bus_reg;
        unique case (mode_reg)
            MODE_ACTIVE: begin
                if (shutdown_en && cmd_is_shdn_in) begin
                    mode_next   = MODE_SHUTDOWN;
                    by_bus_next = 1'b0;
                end else if (shutdown_en && bus_low) begin
                    mode_next   = MODE_SHUTDOWN;
                    by_bus_next = 1'b1;
                end else if (cmd_is_sleep_in) begin
                    mode_next   = MODE_SLEEP;
                    by_bus_next = 1'b0;
                end else if (auto_sleep_req) begin
                    mode_next   = MODE_SLEEP;
                    by_bus_next = 1'b1;
                end
            end
            MODE_SLEEP: begin
                // Exit method must match entry; auto entry leaves on auto release
                if (!by_bus_reg && cmd_is_sleep_out) begin
                    mode_next = MODE_ACTIVE;
                end else if (by_bus_reg && !auto_sleep_req) begin
                    mode_next = MODE_ACTIVE;
                end
            end
            MODE_SHUTDOWN: begin
                if (!by_bus_reg && cmd_is_shdn_out) begin
                    mode_next = MODE_ACTIVE;
                end else if (by_bus_reg && scl_sync_reg[1] && sda_sync_reg[1]) begin
                    mode_next = MODE_ACTIVE;
                end
            end
            default: begin
                mode_next = MODE_ACTIVE;
            end
        endcase
    end

    // Measurement timebase, first estimate and charge level report
    always_comb begin
        cnt_next        = cnt_reg;
        tick_cnt_next   = tick_cnt_reg;
        first_done_next = first_done_reg;
        level_next      = level_reg;
        upd_next        = 1'b0;
        restart_next    = quick_sense;
        sec_tick        = 1'b0;
        dcap_next       = design_cap_wr ? design_cap_wdata : dcap_reg;
        if (quick_sense) begin
            // Restart repeats the 250 ms power-up estimate
            cnt_next        = '0;
            tick_cnt_next   = '0;
            first_done_next = 1'b0;
        end else if (mode_reg == MODE_SHUTDOWN) begin
            cnt_next = cnt_reg;
        end else if (!first_done_reg) begin
            if (cnt_reg == CNT_W'(POR_SETTLE_CYC - 1)) begin
                cnt_next        = '0;
                first_done_next = 1'b1;
                level_next      = soc_calc;
                upd_next        = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end else if (cnt_reg == CNT_W'(ACTIVE_PERIOD_CYC - 1)) begin
            cnt_next = '0;
            sec_tick = 1'b1;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
        if (sec_tick) begin
            if (mode_reg == MODE_ACTIVE) begin
                tick_cnt_next = '0;
                upd_next      = 1'b1;
                level_next    = soc_calc;
            end else if (tick_cnt_reg + 4'h1 >= mult_eff) begin
                tick_cnt_next = '0;
                upd_next      = 1'b1;
                level_next    = soc_calc;
            end else begin
                tick_cnt_next = tick_cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_reg       <= MODE_ACTIVE;
            by_bus_reg     <= 1'b0;
            dcap_reg       <= DESIGN_CAP_RESET;
            level_reg      <= CHARGE_LEVEL_RESET;
            first_done_reg <= 1'b0;
            cnt_reg        <= '0;
            tick_cnt_reg   <= '0;
            upd_reg        <= 1'b0;
            restart_reg    <= 1'b0;
        end else begin
            mode_reg       <= mode_next;
            by_bus_reg     <= by_bus_next;
            dcap_reg       <= dcap_next;
            level_reg      <= level_next;
            first_done_reg <= first_done_next;
            cnt_reg        <= cnt_next;
            tick_cnt_reg   <= tick_cnt_next;
            upd_reg        <= upd_next;
            restart_reg    <= restart_next;
        end
    end

    alert_unit i_alert_unit (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .alert_cond    (alert_cond),
        .alert_en      (armed),
        .irq_en        (irq_en),
        .sc_flag_clear (sc_flag_clear),
        .irq_read      (irq_read),
        .alert_flag    (alert_flag),
        .irq_status    (irq_status),
        .alert_n_oe    (alert_n_oe)
    );

    assign design_capacity_a  = dcap_reg;
    assign charge_level_value = level_reg;
    assign meas_update        = upd_reg;
    assign soc_restart        = restart_reg;
    assign power_mode         = mode_reg;
    assign alert_n_o          = 1'b0;

    // Shutdown must freeze both the update strobe and the reported level
    property p_shdn_freeze;
        @(posedge sys_clk) disable iff (rst)
        (mode_reg == MODE_SHUTDOWN) |=> !upd_reg;
    endproperty
    a_shdn_freeze: assert property (p_shdn_freeze)
        else $error("result update during shutdown");

    property p_shdn_level_hold;
        @(posedge sys_clk) disable iff (rst)
        (mode_reg == MODE_SHUTDOWN && $past(mode_reg) == MODE_SHUTDOWN) |-> $stable(level_reg);
    endproperty
    a_shdn_level_hold: assert property (p_shdn_level_hold)
        else $error("charge level changed in shutdown");

    property p_shdn_needs_en;
        @(posedge sys_clk) disable iff (rst)
        (mode_reg == MODE_ACTIVE && !shutdown_en) |=> mode_reg != MODE_SHUTDOWN;
    endproperty
    a_shdn_needs_en: assert property (p_shdn_needs_en)
        else $error("shutdown without enable");

    property p_quick_restart;
        @(posedge sys_clk) disable iff (rst)
        quick_sense |=> (soc_restart && cnt_reg == '0 && !first_done_reg);
    endproperty
    a_quick_restart: assert property (p_quick_restart)
        else $error("quick sense did not restart");

    // Exit must use the entry method, so the wrong exit leaves the mode alone
    property p_cmd_exit_only;
        @(posedge sys_clk) disable iff (rst)
        (mode_reg == MODE_SLEEP && !by_bus_reg && !cmd_is_sleep_out) |=> mode_reg == MODE_SLEEP;
    endproperty
    a_cmd_exit_only: assert property (p_cmd_exit_only)
        else $error("command sleep left without exit command");

    property p_bus_exit_only;
        @(posedge sys_clk) disable iff (rst)
        (mode_reg == MODE_SHUTDOWN && by_bus_reg && !(scl_sync_reg[1] && sda_sync_reg[1]))
            |=> mode_reg == MODE_SHUTDOWN;
    endproperty
    a_bus_exit_only: assert property (p_bus_exit_only)
        else $error("bus shutdown left before bus release");

    property p_first_update;
        @(posedge sys_clk) disable iff (rst)
        $rose(first_done_reg) |-> upd_reg;
    endproperty
    a_first_update: assert property (p_first_update)
        else $error("first estimate without update");

    property p_active_refresh;
        @(posedge sys_clk) disable iff (rst)
        (sec_tick && mode_reg == MODE_ACTIVE) |=> upd_reg;
    endproperty
    a_active_refresh: assert property (p_active_refresh)
        else $error("no refresh on active second tick");
endmodule : gauge_power_mode_alert_ctrl
`default_nettype wire

// file: host_model.sv
// Host side of the serial bus: holds both bus lines low on request
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic sys_clk,
    input  wire logic bus_low_req,
    output logic      scl_in,
    output logic      sda_in
);
    import gauge_pkg::*;
    // Address the host would send; framing itself is outside this block
    localparam logic [6:0] TARGET_ADDR = I2C_SLAVE_ADDR;

    // Released lines float to the pull-up level, never to the last driven value
    initial begin
        scl_in = 1'b1;
        sda_in = 1'b1;
    end

    // Bus-low entry, and release high as the only exit from it
    // Moving on the rising edge by non-blocking assignment avoids a race with the bench
    always @(posedge sys_clk) begin
        scl_in <= !bus_low_req;
        sda_in <= !bus_low_req;
    end
endmodule : host_model
`default_nettype wire

// file: tb_gauge_power_mode_alert_ctrl.sv
// Self-checking testbench of the gauge power mode and alert controller
`timescale 1ns/1ps
`default_nettype none
module tb_gauge_power_mode_alert_ctrl;
    import gauge_pkg::*;
    logic                  sys_clk, rst, ctrl_wr, design_cap_wr, shutdown_en;
    logic                  auto_sleep_req, irq_en, sc_flag_clear, irq_read, bus_low_req;
    logic [15:0]           ctrl_wdata, design_cap_wdata, design_capacity_a;
    logic [3:0]            sleep_mult;
    logic [7:0]            soc_calc, charge_level_value;
    logic [NUM_ALERTS-1:0] alert_cond, alert_en, alert_thr_set, alert_flag;
    logic                  scl_in, sda_in, meas_update, soc_restart;
    logic                  irq_status, alert_n_o, alert_n_oe;
    power_mode_t           power_mode;
    int                    n_mismatch = 0;
    int                    check_count = 0;

    gauge_power_mode_alert_ctrl i_gauge_power_mode_alert_ctrl (
        .sys_clk(sys_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .design_cap_wr(design_cap_wr), .design_cap_wdata(design_cap_wdata),
        .sleep_mult(sleep_mult), .shutdown_en(shutdown_en),
        .auto_sleep_req(auto_sleep_req), .scl_in(scl_in), .sda_in(sda_in),
        .soc_calc(soc_calc), .alert_cond(alert_cond), .alert_en(alert_en),
        .alert_thr_set(alert_thr_set), .irq_en(irq_en), .sc_flag_clear(sc_flag_clear),
        .irq_read(irq_read), .design_capacity_a(design_capacity_a),
        .charge_level_value(charge_level_value), .meas_update(meas_update),
        .soc_restart(soc_restart), .power_mode(power_mode), .alert_flag(alert_flag),
        .irq_status(irq_status), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe));

    host_model i_host_model (
        .sys_clk(sys_clk), .bus_low_req(bus_low_req), .scl_in(scl_in), .sda_in(sda_in));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    // Strobe lasts one cycle; outputs are settled at the negedge that ends it
    task automatic wr_ctrl(input logic [15:0] d);
        @(negedge sys_clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = d;
        @(negedge sys_clk);
        ctrl_wr = 1'b0;
    endtask : wr_ctrl

    task automatic rd_irq();
        @(negedge sys_clk);
        irq_read = 1'b1;
        @(negedge sys_clk);
        irq_read = 1'b0;
    endtask : rd_irq

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // Tests need well under a thousand cycles; this span leaves wide margin
    initial begin
        #500000;
        n_mismatch++;
        conclude();
    end

    initial begin
        logic [NUM_ALERTS-1:0] m;
        rst = 1'b1; ctrl_wr = 1'b0; ctrl_wdata = 16'h0000; design_cap_wr = 1'b0;
        design_cap_wdata = 16'h0000; sleep_mult = SLEEP_MULT_RESET; shutdown_en = 1'b0;
        auto_sleep_req = 1'b0; soc_calc = 8'h4b; alert_cond = '0; alert_en = '0;
        alert_thr_set = '0; irq_en = 1'b0; sc_flag_clear = 1'b0; irq_read = 1'b0;
        bus_low_req = 1'b0;
        tick(10);
        rst = 1'b0;
        check("cap_reset", design_capacity_a, DESIGN_CAP_RESET);
        check("level_reset", charge_level_value, CHARGE_LEVEL_RESET);
        check("mode_reset", power_mode, MODE_ACTIVE);
        check("flag_reset", alert_flag, 16'h0000);
        check("pin_reset", alert_n_oe, 16'h0000);
        // Host loads the real capacity once after reset
        design_cap_wr = 1'b1;
        design_cap_wdata = 16'h0bb8;
        tick(1);
        design_cap_wr = 1'b0;
        check("cap_write", design_capacity_a, 16'h0bb8);
        wr_ctrl(CMD_QUICK_SENSE);
        check("restart_pulse", soc_restart, 16'h0001);
        tick(1);
        check("restart_end", soc_restart, 16'h0000);
        // Command sleep ignores the automatic exit path
        wr_ctrl(CMD_SLEEP_ENTER);
        check("cmd_sleep", power_mode, MODE_SLEEP);
        tick(3);
        check("cmd_sleep_hold", power_mode, MODE_SLEEP);
        wr_ctrl(CMD_SLEEP_EXIT);
        check("cmd_wake", power_mode, MODE_ACTIVE);
        auto_sleep_req = 1'b1;
        tick(3);
        check("auto_sleep", power_mode, MODE_SLEEP);
        wr_ctrl(CMD_SLEEP_EXIT);
        check("auto_wrong_exit", power_mode, MODE_SLEEP);
        auto_sleep_req = 1'b0;
        tick(3);
        check("auto_wake", power_mode, MODE_ACTIVE);
        // Shutdown refused while the function is off
        wr_ctrl(CMD_SHDN_ENTER);
        bus_low_req = 1'b1;
        tick(8);
        check("shdn_disabled", power_mode, MODE_ACTIVE);
        bus_low_req = 1'b0;
        // Enable only once the released bus has passed the synchroniser
        tick(6);
        check("bus_idle", power_mode, MODE_ACTIVE);
        shutdown_en = 1'b1;
        wr_ctrl(CMD_SHDN_ENTER);
        check("cmd_shdn", power_mode, MODE_SHUTDOWN);
        for (int k = 0; k < 8; k++) begin
            tick(1);
            check("shdn_no_update", meas_update, 16'h0000);
        end
        wr_ctrl(CMD_SHDN_EXIT);
        check("cmd_shdn_exit", power_mode, MODE_ACTIVE);
        bus_low_req = 1'b1;
        tick(8);
        check("bus_shdn", power_mode, MODE_SHUTDOWN);
        wr_ctrl(CMD_SHDN_EXIT);
        check("bus_wrong_exit", power_mode, MODE_SHUTDOWN);
        bus_low_req = 1'b0;
        tick(8);
        check("bus_release", power_mode, MODE_ACTIVE);
        shutdown_en = 1'b0;
        // Every alert source through set, interrupt, clear and disarm
        for (int i = 0; i < NUM_ALERTS; i++) begin
            m = NUM_ALERTS'(1) << i;
            irq_en = 1'b1;
            alert_en = m;
            alert_cond = m;
            tick(1);
            check("flag_set", alert_flag, m);
            check("irq_set", irq_status, 16'h0001);
            check("pin_low", {alert_n_oe, alert_n_o}, 16'h0002);
            rd_irq();
            check("irq_clear", {irq_status, alert_n_oe}, 16'h0000);
            tick(3);
            check("no_new_irq", irq_status, 16'h0000);
            alert_cond = '0;
            tick(1);
            check("cond_gone", alert_flag, (i == SC_ALERT_IDX) ? m : '0);
            sc_flag_clear = 1'b1;
            tick(1);
            sc_flag_clear = 1'b0;
            check("host_clear", alert_flag, 16'h0000);
            alert_en = '0;
            alert_cond = m;
            tick(2);
            check("unarmed", {alert_flag, irq_status}, 16'h0000);
            alert_thr_set = m;
            tick(1);
            check("thr_arm", {alert_flag, irq_status}, {m, 1'b1});
            irq_en = 1'b0;
            alert_thr_set = '0;
            tick(1);
            check("disarm", alert_flag, 16'h0000);
            check("irq_kept", {irq_status, alert_n_oe}, 16'h0003);
            alert_cond = '0;
            rd_irq();
        end
        // Reset in mid-run from auto sleep with a written capacity
        auto_sleep_req = 1'b1;
        tick(3);
        check("pre_reset_sleep", power_mode, MODE_SLEEP);
        rst = 1'b1;
        auto_sleep_req = 1'b0;
        tick(2);
        rst = 1'b0;
        check("cap_rereset", design_capacity_a, DESIGN_CAP_RESET);
        check("mode_rereset", power_mode, MODE_ACTIVE);
        check("irq_rereset", {irq_status, alert_n_oe}, 16'h0000);
        tick(3);
        check("mode_after_rereset", power_mode, MODE_ACTIVE);
        conclude();
    end
endmodule : tb_gauge_power_mode_alert_ctrl
`default_nettype wire
